// file: lctf_top.sv
// led colour trim and frame fetch pointer, with its frame word fifo
// assumes a classic wishbone master, a memory port answering one word per
// request, and a pwm engine on the same clock that takes pixels on demand
//
// Summary of operation
// - trim bytes are signed, -128 to 127
// - blue trim added to blue at load
// - fetch pointer advances on every dma load without a pointer write in the same cycle
// - pointer holds 16 bits, word aligned only
// - red, green, luminance get own trims
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module lctf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [AW:0]           level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign level     = wr_q - rd_q;
  // full at DEPTH entries; cast to AW+1 bits, an AW-bit cast of DEPTH is zero
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : lctf_fifo

module lctf_top (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [lctf_pkg::LCTF_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               mem_req,
  output logic [lctf_pkg::LCTF_PTR_W-1:0]    mem_addr,
  input  wire logic                          mem_ack,
  input  wire logic [31:0]                   mem_rdata,
  input  wire logic                          pwm_load_ready,
  output logic                               pwm_valid,
  output lctf_pkg::lctf_pixel_s              pwm_data
);
  import lctf_pkg::*;

  // signed trim on an unsigned intensity, clamped to 0..255
  // clamped rather than wrapped, so a large trim never turns a bright channel dark
  function automatic logic [7:0] trim_add(input logic [7:0] data, input logic [7:0] trim);
    logic signed [9:0] sum;
    sum = $signed({2'b00, data}) + $signed({{2{trim[7]}}, trim});
    if (sum < 10'sd0) begin
      trim_add = 8'h00;
    end else if (sum > 10'sd255) begin
      trim_add = 8'hFF;
    end else begin
      trim_add = sum[7:0];
    end
  endfunction : trim_add

  lctf_trim_s           trim_q;
  lctf_trim_s           trim_d;
  logic [15:0]          ptr_q;
  logic [15:0]          ptr_d;
  logic                 en_q;
  logic                 en_d;
  logic                 ack_q;
  logic                 ack_d;
  logic [31:0]          rdat_q;
  logic [31:0]          rdat_d;
  lctf_fetch_e          st_q;
  lctf_fetch_e          st_d;
  logic                 req_q;
  logic                 req_d;
  logic [31:0]          word_q;
  logic [31:0]          word_d;
  logic                 pv_q;
  logic                 pv_d;
  lctf_pixel_s          pix_q;
  lctf_pixel_s          pix_d;

  logic                 bus_hit;
  logic                 bus_wr;
  logic [5:0]           idx;
  logic                 f_in_valid;
  logic                 f_in_ready;
  logic                 f_out_valid;
  logic                 f_out_ready;
  logic [31:0]          f_out_data;
  logic [LCTF_FIFO_AW:0] f_level;

  assign idx     = wb_adr_i[LCTF_ADR_W-1:2];
  assign bus_hit = wb_cyc_i && wb_stb_i && !ack_q;
  // a write lands on the edge at which the master sees ack, while its request
  // still stands; the master releases right after, so it lands exactly once
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  // bus slave: one-cycle ack, unmapped reads zero, unmapped writes dropped
  // read data is registered with ack, so it stands for the whole ack cycle
  always_comb begin
    ack_d  = bus_hit;
    rdat_d = rdat_q;
    trim_d = trim_q;
    en_d   = en_q;
    if (bus_hit && !wb_we_i) begin
      rdat_d = 32'h0000_0000;
      case (idx)
        LCTF_IDX_LUM_TRIM:   rdat_d[7:0] = trim_q.lum;
        LCTF_IDX_RED_TRIM:   rdat_d[7:0] = trim_q.red;
        LCTF_IDX_GREEN_TRIM: rdat_d[7:0] = trim_q.green;
        LCTF_IDX_BLUE_TRIM:  rdat_d[7:0] = trim_q.blue;
        LCTF_IDX_FETCH_PTR:  rdat_d[15:0] = ptr_q;
        LCTF_IDX_CTRL:       rdat_d[LCTF_CTRL_EN_BIT] = en_q;
        // busy is any fetch state but idle
        LCTF_IDX_STATUS: begin
          rdat_d[LCTF_STAT_CNT_LSB +: LCTF_FIFO_AW+1] = f_level;
          rdat_d[LCTF_STAT_BUSY_BIT] = !st_q[0];
        end
        default:             rdat_d = 32'h0000_0000;
      endcase
    end
    if (bus_wr && wb_sel_i[0]) begin
      case (idx)
        LCTF_IDX_LUM_TRIM:   trim_d.lum   = wb_dat_i[7:0];
        LCTF_IDX_RED_TRIM:   trim_d.red   = wb_dat_i[7:0];
        LCTF_IDX_GREEN_TRIM: trim_d.green = wb_dat_i[7:0];
        LCTF_IDX_BLUE_TRIM:  trim_d.blue  = wb_dat_i[7:0];
        LCTF_IDX_CTRL:       en_d = wb_dat_i[LCTF_CTRL_EN_BIT];
        default:             en_d = en_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      trim_q <= {4{LCTF_TRIM_RESET}};
      en_q   <= 1'b0;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      trim_q <= trim_d;
      en_q   <= en_d;
    end
  end

  // fetch sequencer; only starts with room in the fifo, one word in flight,
  // so a fetched word never waits on a full fifo for long
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    word_d = word_q;
    ptr_d  = ptr_q;
    case (st_q)
      LCTF_F_IDLE: begin
        if (en_q && f_in_ready) begin
          st_d  = LCTF_F_REQ;
          req_d = 1'b1;
        end
      end
      LCTF_F_REQ: begin
        if (mem_ack) begin
          st_d   = LCTF_F_PUSH;
          req_d  = 1'b0;
          word_d = mem_rdata;
          // 16-bit add, wraps within the pointer field
          ptr_d  = ptr_q + LCTF_PTR_STEP;
        end
      end
      LCTF_F_PUSH: begin
        if (f_in_ready) begin
          st_d = LCTF_F_IDLE;
        end
      end
      default: begin
        st_d  = LCTF_F_IDLE;
        req_d = 1'b0;
      end
    endcase
    // software write wins over the increment; low two bits forced to zero
    if (bus_wr && idx == LCTF_IDX_FETCH_PTR) begin
      if (wb_sel_i[0]) begin
        ptr_d[7:0] = wb_dat_i[7:0] & LCTF_PTR_ALIGN[7:0];
      end
      if (wb_sel_i[1]) begin
        ptr_d[15:8] = wb_dat_i[15:8];
      end
    end
  end

  assign f_in_valid = st_q[2];

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= LCTF_F_IDLE;
      req_q  <= 1'b0;
      word_q <= 32'h0000_0000;
      ptr_q  <= LCTF_PTR_RESET;
    end else begin
      st_q   <= st_d;
      req_q  <= req_d;
      word_q <= word_d;
      ptr_q  <= ptr_d;
    end
  end

  // both straight from flops; the memory sees a steady request until it answers
  assign mem_req  = req_q;
  assign mem_addr = ptr_q;

  lctf_fifo #(
    .WIDTH (LCTF_FIFO_WIDTH),
    .DEPTH (LCTF_FIFO_DEPTH),
    .AW    (LCTF_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (word_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // load stage: trims applied as each pixel leaves for the pwm
  // at most one pixel every other cycle; the pwm engine loads far slower than that
  assign f_out_ready = pwm_load_ready && !pv_q;

  always_comb begin
    pv_d  = 1'b0;
    pix_d = pix_q;
    if (f_out_valid && f_out_ready) begin
      pv_d        = 1'b1;
      pix_d.lum   = trim_add(f_out_data[LCTF_LUM_LSB +: 8], trim_q.lum);
      pix_d.red   = trim_add(f_out_data[LCTF_RED_LSB +: 8], trim_q.red);
      pix_d.green = trim_add(f_out_data[LCTF_GREEN_LSB +: 8], trim_q.green);
      pix_d.blue  = trim_add(f_out_data[LCTF_BLUE_LSB +: 8], trim_q.blue);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pv_q  <= 1'b0;
      pix_q <= '0;
    end else begin
      pv_q  <= pv_d;
      pix_q <= pix_d;
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;
  assign pwm_valid = pv_q;
  assign pwm_data  = pix_q;
endmodule : lctf_top

`default_nettype wire

// file: lctf_pkg.sv
// constants and types for the led colour trim and frame fetch block
// assumes a 32-bit classic wishbone slave port and a 100 MHz clock
package lctf_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] LCTF_IDX_LUM_TRIM   = 6'h14;
  localparam logic [5:0] LCTF_IDX_RED_TRIM   = 6'h15;
  localparam logic [5:0] LCTF_IDX_GREEN_TRIM = 6'h16;
  localparam logic [5:0] LCTF_IDX_BLUE_TRIM  = 6'h17;
  localparam logic [5:0] LCTF_IDX_FETCH_PTR  = 6'h18;
  localparam logic [5:0] LCTF_IDX_CTRL       = 6'h19;
  localparam logic [5:0] LCTF_IDX_STATUS     = 6'h1A;

  localparam int         LCTF_ADR_W         = 8;
  localparam int         LCTF_PTR_W         = 16;
  localparam logic [7:0] LCTF_TRIM_RESET    = 8'h00;
  localparam logic [15:0] LCTF_PTR_RESET    = 16'h0000;
  localparam logic [15:0] LCTF_PTR_STEP     = 16'h0004;
  localparam logic [15:0] LCTF_PTR_ALIGN    = 16'hFFFC;

  // control and status fields
  localparam int LCTF_CTRL_EN_BIT    = 0;
  localparam int LCTF_STAT_CNT_LSB   = 0;
  localparam int LCTF_STAT_BUSY_BIT  = 4;

  // fetched word layout, byte lanes
  localparam int LCTF_LUM_LSB   = 0;
  localparam int LCTF_RED_LSB   = 8;
  localparam int LCTF_GREEN_LSB = 16;
  localparam int LCTF_BLUE_LSB  = 24;

  localparam int LCTF_FIFO_WIDTH = 32;
  localparam int LCTF_FIFO_DEPTH = 8;
  localparam int LCTF_FIFO_AW    = 3;

  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
    logic [7:0] lum;
  } lctf_pixel_s;

  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
    logic [7:0] lum;
  } lctf_trim_s;

  typedef enum logic [2:0] {
    LCTF_F_IDLE = 3'b001,
    LCTF_F_REQ  = 3'b010,
    LCTF_F_PUSH = 3'b100
  } lctf_fetch_e;

endpackage : lctf_pkg

// file: lctf_monitor.sv
// checker on the fetch, bus and pixel ports of lctf_top
// assumes one clock and a synchronous reset; bound below
`timescale 1ns/1ps
`default_nettype none
module lctf_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        pwm_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_addr_step: assert property (mem_ack |=> mem_addr == $past(mem_addr) + 16'h0004)
    else $error("pointer did not step by four");
  chk_addr_align: assert property (mem_addr[1:0] == 2'h0)
    else $error("pointer not word aligned");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped or moved");
  chk_req_gap: assert property (mem_ack |=> !mem_req [*2])
    else $error("fetch request too soon after answer");
  chk_pix_pulse: assert property (pwm_valid |=> !pwm_valid)
    else $error("pixel pulse longer than one cycle");
  chk_reg_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register access not answered in one cycle");
endmodule : lctf_monitor
bind lctf_top lctf_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .pwm_valid(pwm_valid));
`default_nettype wire

// file: lctf_mem_model.sv
// frame memory model: word derived from address, answer after lat+1 cycles
// assumes one request in flight, held until answered
`timescale 1ns/1ps
`default_nettype none
module lctf_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [3:0] wait_q;
  logic [7:0] a;
  assign a = mem_addr[7:0];
  always_ff @(posedge clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;  // no stale word outside an answer
    wait_q    <= 4'h0;
    if (rst) begin
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_q >= lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= {a ^ 8'h55, a + 8'h80, ~a, a};
    end else if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : lctf_mem_model
`default_nettype wire

// file: lctf_tb.sv
// bench for lctf_top: trims, fetch pointer, fifo fill and drain
// assumes lctf_mem_model as memory and lctf_monitor bound to the top
`timescale 1ns/1ps
`default_nettype none
module lctf_tb;
  import lctf_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rdy = 0, ack, mreq, mack, pv;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, lat = 0;
  logic [31:0] wdat = 0, rdat, mdat, r;
  logic [15:0] maddr, ea;
  lctf_pixel_s pd;
  int          n_errors = 0, compares = 0, ncyc = 0, n;
  // per row: trim word (blue green red lum) above the pixel it must give,
  // for frame words at 0xFFF8, 0xFFFC, 0x0000, 0x0004, 0x0008 in turn
  logic [63:0] rows [5] = '{{32'h00000000, 32'hAD7807F8}, {32'h7F7F7F7F, 32'hFFFB82FF},
    {32'h80808080, 32'h00007F00}, {32'h7F80017F, 32'hD004FC83}, {32'hFF01807F, 32'h5C897787}};
  lctf_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_req(mreq), .mem_addr(maddr),
    .mem_ack(mack), .mem_rdata(mdat), .pwm_load_ready(rdy), .pwm_valid(pv), .pwm_data(pd));
  lctf_mem_model MEM (.clk(clk), .rst(rst), .lat(lat), .mem_req(mreq), .mem_addr(maddr),
    .mem_ack(mack), .mem_rdata(mdat));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t reg got %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_pix(input lctf_pixel_s g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t pixel got %h exp %h", $time, g, e);
    end
  endtask : chk_pix
  // read data and ack are taken at the edge the answer is sampled
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, idx, 2'b00, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask : wb
  function automatic logic [31:0] expx(input logic [15:0] a, input logic [31:0] t);
    logic [31:0] w, e;
    int s;
    w = {a[7:0] ^ 8'h55, a[7:0] + 8'h80, ~a[7:0], a[7:0]};
    for (int i = 0; i < 4; i++) begin
      s = int'(w[8*i+:8]) + int'($signed(t[8*i+:8]));
      e[8*i+:8] = s < 0 ? 8'h00 : s > 255 ? 8'hFF : s[7:0];
    end
    return e;
  endfunction : expx
  // ready held until the pulse so exactly one pixel leaves; an edge passes before the next
  task automatic pop(input logic [31:0] e);
    rdy <= 1'b1;
    do @(posedge clk); while (pv !== 1'b1);
    rdy <= 1'b0;
    chk_pix(pd, e);
    ea = ea + 16'h0004;
    @(posedge clk);
  endtask : pop
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, LCTF_IDX_FETCH_PTR, 32'hFFFA, 4'h3);
    wb(1'b0, LCTF_IDX_FETCH_PTR, 32'h0, 4'hF);
    chk_reg(r, 32'hFFF8);
    ea = 16'hFFF8;
    wb(1'b1, LCTF_IDX_CTRL, 32'h1, 4'h1);
    wb(1'b0, LCTF_IDX_CTRL, 32'h0, 4'hF);
    chk_reg(r, 32'h1);
    repeat (80) @(posedge clk);
    wb(1'b0, LCTF_IDX_STATUS, 32'h0, 4'hF);
    chk_reg(r & 32'h1F, 32'h8);
    chk_reg({31'h0, mreq}, 32'h0);
    $display("fifo fill done");
    for (int k = 0; k < 5; k++) begin
      lat <= 4'(k);
      for (int i = 0; i < 4; i++) wb(1'b1, LCTF_IDX_LUM_TRIM + 6'(i), {24'h0, rows[k][32+8*i+:8]}, 4'h1);
      pop(rows[k][31:0]);
      $display("row %0d done", k);
    end
    wb(1'b1, LCTF_IDX_BLUE_TRIM, 32'hAB, 4'hE);
    wb(1'b0, LCTF_IDX_BLUE_TRIM, 32'h0, 4'hF);
    chk_reg(r, 32'hFF);
    wb(1'b0, 6'h3F, 32'h0, 4'hF);
    chk_reg(r, 32'h0);
    wb(1'b0, LCTF_IDX_GREEN_TRIM, 32'h0, 4'hF);
    chk_reg(r, 32'h01);
    wb(1'b1, LCTF_IDX_CTRL, 32'h0, 4'h1);
    while (mreq === 1'b1) @(posedge clk);
    wb(1'b0, LCTF_IDX_STATUS, 32'h0, 4'hF);
    n = int'(r[3:0]);
    repeat (n) pop(expx(ea, rows[4][63:32]));
    wb(1'b0, LCTF_IDX_STATUS, 32'h0, 4'hF);
    chk_reg(r & 32'h1F, 32'h0);
    wb(1'b0, LCTF_IDX_FETCH_PTR, 32'h0, 4'hF);
    chk_reg(r, {16'h0, ea});
    $display("drain done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, LCTF_IDX_BLUE_TRIM, 32'h0, 4'hF);
    chk_reg(r, 32'h0);
    wb(1'b0, LCTF_IDX_FETCH_PTR, 32'h0, 4'hF);
    chk_reg(r, 32'h0);
    chk_pix(pd, 32'h0);
    $display("reset done");
    tally_and_finish();
  end
endmodule : lctf_tb
`default_nettype wire
